/* File: design/smrp_pkg.sv */
package smrp_pkg;

  // ----------------------------------------
  // Block geometry
  // ----------------------------------------
  localparam int STEPS = 18;
  localparam int CTRL_WORDS = 2 + 6 * STEPS;
  localparam int MON_WORDS = 9;

  // Word indices on the bus, byte address is four times the index
  localparam logic [9:0] IDX_INT_STEP = 10'h000;
  localparam logic [9:0] IDX_MON_BASE = 10'h080;
  localparam logic [9:0] IDX_CFG = 10'h0C0;
  localparam logic [9:0] IDX_STAT = 10'h0C1;

  // Offsets inside a six-word step record
  localparam int OFS_FREQ = 0;
  localparam int OFS_RAMP = 1;
  localparam int OFS_PRE_A = 2;
  localparam int OFS_PRE_B = 3;
  localparam int OFS_OPTS = 4;
  localparam int OFS_SUCC = 5;

  // Offsets inside the monitor block
  localparam logic [3:0] MON_SUCC = 4'h0;
  localparam logic [3:0] MON_ACT = 4'h1;
  localparam logic [3:0] MON_FREQ = 4'h2;
  localparam logic [3:0] MON_RAMP = 4'h3;
  localparam logic [3:0] MON_PRE_A = 4'h4;
  localparam logic [3:0] MON_PRE_B = 4'h5;
  localparam logic [3:0] MON_CNT_A = 4'h6;
  localparam logic [3:0] MON_CNT_B = 4'h7;
  localparam logic [3:0] MON_ERR = 4'h8;

  // Configuration bits and their reset values
  localparam int CFG_RUN = 0;
  localparam int CFG_HI_FIRST = 1;
  localparam int CFG_MODE = 2;
  localparam logic [2:0] CFG_RESET = 3'h2;

  // Error codes
  localparam logic [3:0] ERR_NONE = 4'h0;
  localparam logic [3:0] ERR_PRESET = 4'h3;
  localparam logic [3:0] ERR_FREQ = 4'h4;
  localparam logic [3:0] ERR_RAMP = 4'h5;
  localparam logic [3:0] ERR_OPTS = 4'h7;
  localparam logic [3:0] ERR_SUCC = 4'h8;
  localparam logic [3:0] ERR_INT = 4'h9;

  // Setting limits
  localparam logic [31:0] PRESET_MAX = 32'h05F5E100;
  localparam logic [15:0] FREQ_MAX = 16'h2710;
  localparam logic [15:0] FREQ_MIN0 = 16'h0001;
  localparam logic [15:0] FREQ_MIN1 = 16'h0014;
  localparam logic [15:0] RAMP_MIN = 16'h000A;
  localparam logic [15:0] RAMP_MAX = 16'h2710;
  localparam logic [15:0] RAMP_UNIT = 16'h000A;
  localparam logic [15:0] OPTS_MAX = 16'h0003;
  localparam logic [15:0] STEP_MAX = 16'h0012;
  localparam logic [15:0] STEP_MIN = 16'h0001;
  localparam logic [19:0] MODE1_SCALE = 20'h0000A;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int SCAN_TIME_US = 1000;
  localparam int TICK_TIME_MS = 10;
  localparam int SCAN_CYCLES = SCAN_TIME_US * (CLK_HZ / 1_000_000);
  localparam int TICK_CYCLES = TICK_TIME_MS * (CLK_HZ / 1000);
  localparam logic [23:0] ACC_HALF = 24'(CLK_HZ / 2);

  // Defaults loaded at reset and by the reload input
  localparam logic [15:0] DEF_INT_STEP = 16'h0001;
  localparam logic [15:0] DEF_FREQ = 16'h0064;
  localparam logic [15:0] DEF_RAMP = 16'h0064;
  localparam logic [31:0] DEF_PRESET = 32'h00000064;
  localparam logic [15:0] DEF_OPTS = 16'h0000;
  localparam logic [15:0] DEF_SUCC = 16'h0000;

  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOAD = 2'b01,
    ST_RUN = 2'b10,
    ST_STOP = 2'b11
  } smrp_state_t;

  typedef struct packed {
    logic [15:0] freq;
    logic [15:0] ramp;
    logic [31:0] preset;
    logic [15:0] opts;
    logic [15:0] succ;
  } smrp_step_t;

  function automatic logic [15:0] smrp_default_word(input int idx, input logic hi_first);
    int ofs;
    ofs = (idx - 2) % 6;
    if (idx == 0) return DEF_INT_STEP;
    if (idx == 1) return 16'h0000;
    case (ofs)
      OFS_FREQ: return DEF_FREQ;
      OFS_RAMP: return DEF_RAMP;
      OFS_PRE_A: return hi_first ? DEF_PRESET[31:16] : DEF_PRESET[15:0];
      OFS_PRE_B: return hi_first ? DEF_PRESET[15:0] : DEF_PRESET[31:16];
      OFS_OPTS: return DEF_OPTS;
      default: return DEF_SUCC;
    endcase
  endfunction

endpackage

/* File: design/smrp_stepped_ramp_pulser.sv */
// Contract
// - Control block is two header words plus six words per step, contiguous.
// - Step settings are captured at step start; later writes wait for next start.
// - Global word-order bit picks which preset half sits at lower address.
// - Step record order: frequency, change time, preset hi, lo, options, next.
// - While reload input is high, defaults are rewritten every scan.
// - Interrupt rising edge aborts step and restarts at header interrupt step.
// - Fast-class interrupt input is sampled every clock, apart from scan.
// - Normal-class interrupt input is sampled only at end of scan.
// - Monitor block is nine words: next, running, freq, time, preset, count, error.
// - Only the generator writes monitor words; bus writes there are refused.
// - Next step zero ends pulse output after current step completes.
// - Each step start validates settings and stores error code 0,3,4,5,7,8,9.
// - Monitor current count is refreshed once per scan.
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
module smrp_stepped_ramp_pulser
  import smrp_pkg::*;
#(
  parameter int SCAN_CYC = SCAN_CYCLES,
  parameter int TICK_CYC = TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // AXI4-Lite write
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Control inputs
  input wire logic defaults_reload_in,
  input wire logic step_interrupt_in,
  input wire logic interrupt_fast_sel,
  // Pulse side
  output logic pulse_out,
  output logic pulse_busy,
  output logic pulse_done,
  output logic program_error_flag
);

  // ----------------------------------------
  // Storage and state
  // ----------------------------------------
  logic [15:0] ctrl_mem [CTRL_WORDS];
  logic [2:0] cfg;
  smrp_state_t state;
  smrp_step_t cap;
  logic [4:0] step_no;
  logic from_int;
  logic [15:0] mon_succ, mon_act;
  logic [31:0] mon_cnt;
  logic [3:0] err_code;
  logic [31:0] cnt;
  logic [15:0] cur_f, tgt_f, delta, rt10, hold_left, racc;
  logic [23:0] pacc;
  logic holding;
  logic [15:0] scan_cnt;
  logic [17:0] tick_cnt;
  logic scan_tick, tick;
  logic int_q, int_scan;

  // ----------------------------------------
  // Scan and time base
  // ----------------------------------------
  // The scan period models the controller's program scan; END work runs on scan_tick
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scan_cnt <= 16'h0000;
      scan_tick <= 1'b0;
    end else if (scan_cnt == 16'(SCAN_CYC - 1)) begin
      scan_cnt <= 16'h0000;
      scan_tick <= 1'b1;
    end else begin
      scan_cnt <= scan_cnt + 16'h0001;
      scan_tick <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt <= 18'h00000;
      tick <= 1'b0;
    end else if (tick_cnt == 18'(TICK_CYC - 1)) begin
      tick_cnt <= 18'h00000;
      tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 18'h00001;
      tick <= 1'b0;
    end
  end

  // ----------------------------------------
  // Interrupt sampling
  // ----------------------------------------
  logic int_edge;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      int_q <= 1'b0;
      int_scan <= 1'b0;
    end else begin
      int_q <= step_interrupt_in;
      if (scan_tick) begin
        int_scan <= step_interrupt_in;
      end
    end
  end

  always_comb begin
    if (interrupt_fast_sel) begin
      int_edge = step_interrupt_in & ~int_q;
    end else begin
      int_edge = scan_tick & step_interrupt_in & ~int_scan;
    end
  end

  // ----------------------------------------
  // Bus handshakes
  // ----------------------------------------
  logic aw_hold, w_hold, do_wr, aw_take, w_take, ar_take;
  logic next_aw_hold, next_w_hold, next_rvalid;
  logic [9:0] wr_idx;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_ctrl;

  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take = s_axi_wvalid & s_axi_wready;
  assign ar_take = s_axi_arvalid & s_axi_arready;
  assign do_wr = aw_hold & w_hold & ~s_axi_bvalid;
  assign next_aw_hold = (aw_hold | aw_take) & ~do_wr;
  assign next_w_hold = (w_hold | w_take) & ~do_wr;
  assign next_rvalid = (s_axi_rvalid & ~s_axi_rready) | ar_take;
  assign wr_ctrl = do_wr && (wr_idx < 10'(CTRL_WORDS));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      wr_idx <= 10'h000;
      wr_data <= 32'h00000000;
      wr_strb <= 4'h0;
    end else begin
      aw_hold <= next_aw_hold;
      w_hold <= next_w_hold;
      s_axi_awready <= ~next_aw_hold;
      s_axi_wready <= ~next_w_hold;
      if (aw_take) begin
        wr_idx <= s_axi_awaddr[11:2];
      end
      if (w_take) begin
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (do_wr) begin
      s_axi_bvalid <= 1'b1;
      if (wr_ctrl || wr_idx == IDX_CFG) begin
        s_axi_bresp <= RESP_OKAY;
      end else if ((wr_idx >= IDX_MON_BASE && wr_idx < IDX_MON_BASE + 10'(MON_WORDS))
                   || wr_idx == IDX_STAT) begin
        s_axi_bresp <= RESP_SLVERR;
      end else begin
        s_axi_bresp <= RESP_DECERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg <= CFG_RESET;
    end else if (do_wr && wr_idx == IDX_CFG && wr_strb[0]) begin
      cfg <= wr_data[2:0];
    end
  end

  // ----------------------------------------
  // Control words
  // ----------------------------------------
  // Reload is applied at the scan boundary and beats a bus write in that cycle
  logic reload_now;
  assign reload_now = scan_tick & defaults_reload_in;

  for (genvar gi = 0; gi < CTRL_WORDS; gi++) begin : g_ctrl
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        ctrl_mem[gi] <= smrp_default_word(gi, CFG_RESET[CFG_HI_FIRST]);
      end else if (reload_now) begin
        ctrl_mem[gi] <= smrp_default_word(gi, cfg[CFG_HI_FIRST]);
      end else if (wr_ctrl && wr_idx == 10'(gi)) begin
        if (wr_strb[0]) begin
          ctrl_mem[gi][7:0] <= wr_data[7:0];
        end
        if (wr_strb[1]) begin
          ctrl_mem[gi][15:8] <= wr_data[15:8];
        end
      end
    end
  end

  // ----------------------------------------
  // Register read
  // ----------------------------------------
  logic [9:0] rd_idx;
  logic [31:0] rd_data;
  logic [1:0] rd_resp;
  logic [3:0] mon_ofs;
  logic [31:0] stat_word;
  assign rd_idx = s_axi_araddr[11:2];
  assign mon_ofs = 4'(rd_idx - IDX_MON_BASE);
  assign stat_word = {19'h00000, step_no, 4'h0, holding, pulse_done, program_error_flag,
                      pulse_busy};

  always_comb begin
    rd_data = 32'h00000000;
    rd_resp = RESP_OKAY;
    if (rd_idx < 10'(CTRL_WORDS)) begin
      rd_data = {16'h0000, ctrl_mem[rd_idx[6:0]]};
    end else if (rd_idx >= IDX_MON_BASE && rd_idx < IDX_MON_BASE + 10'(MON_WORDS)) begin
      case (mon_ofs)
        MON_SUCC: rd_data[15:0] = mon_succ;
        MON_ACT: rd_data[15:0] = mon_act;
        MON_FREQ: rd_data[15:0] = cap.freq;
        MON_RAMP: rd_data[15:0] = cap.ramp;
        MON_PRE_A: rd_data[15:0] = cfg[CFG_HI_FIRST] ? cap.preset[31:16] : cap.preset[15:0];
        MON_PRE_B: rd_data[15:0] = cfg[CFG_HI_FIRST] ? cap.preset[15:0] : cap.preset[31:16];
        MON_CNT_A: rd_data[15:0] = cfg[CFG_HI_FIRST] ? mon_cnt[31:16] : mon_cnt[15:0];
        MON_CNT_B: rd_data[15:0] = cfg[CFG_HI_FIRST] ? mon_cnt[15:0] : mon_cnt[31:16];
        default: rd_data[15:0] = {12'h000, err_code};
      endcase
    end else if (rd_idx == IDX_CFG) begin
      rd_data = {29'h00000000, cfg};
    end else if (rd_idx == IDX_STAT) begin
      rd_data = stat_word;
    end else begin
      rd_resp = RESP_DECERR;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_rvalid <= next_rvalid;
      s_axi_arready <= ~next_rvalid;
      if (ar_take) begin
        s_axi_rdata <= rd_data;
        s_axi_rresp <= rd_resp;
      end
    end
  end

  // ----------------------------------------
  // Step fetch and check
  // ----------------------------------------
  logic [6:0] rec;
  smrp_step_t ld;
  logic [3:0] ld_err;
  logic [15:0] int_word;
  logic step_ok;
  assign int_word = ctrl_mem[IDX_INT_STEP[6:0]];
  assign step_ok = step_no >= STEP_MIN[4:0] && step_no <= STEP_MAX[4:0];
  // Out-of-range step numbers read record 1; the error path discards it
  assign rec = step_ok ? 7'(6 * int'(step_no) - 4) : 7'd2;

  always_comb begin
    ld.freq = ctrl_mem[rec + 7'(OFS_FREQ)];
    ld.ramp = ctrl_mem[rec + 7'(OFS_RAMP)];
    if (cfg[CFG_HI_FIRST]) begin
      ld.preset = {ctrl_mem[rec + 7'(OFS_PRE_A)], ctrl_mem[rec + 7'(OFS_PRE_B)]};
    end else begin
      ld.preset = {ctrl_mem[rec + 7'(OFS_PRE_B)], ctrl_mem[rec + 7'(OFS_PRE_A)]};
    end
    ld.opts = ctrl_mem[rec + 7'(OFS_OPTS)];
    ld.succ = ctrl_mem[rec + 7'(OFS_SUCC)];
    if (from_int && (int_word < STEP_MIN || int_word > STEP_MAX)) begin
      ld_err = ERR_INT;
    end else if (ld.preset == 32'h00000000 || ld.preset > PRESET_MAX) begin
      ld_err = ERR_PRESET;
    end else if (ld.freq > FREQ_MAX
                 || ld.freq < (cfg[CFG_MODE] ? FREQ_MIN1 : FREQ_MIN0)) begin
      ld_err = ERR_FREQ;
    end else if (ld.ramp < RAMP_MIN || ld.ramp > RAMP_MAX) begin
      ld_err = ERR_RAMP;
    end else if (ld.opts > OPTS_MAX) begin
      ld_err = ERR_OPTS;
    end else if (ld.succ > STEP_MAX) begin
      ld_err = ERR_SUCC;
    end else begin
      ld_err = ERR_NONE;
    end
  end

  // ----------------------------------------
  // Step sequencer
  // ----------------------------------------
  logic run_en, step_end;
  assign run_en = cfg[CFG_RUN];
  assign step_end = cnt >= cap.preset;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      step_no <= 5'h01;
      from_int <= 1'b0;
      cap <= '0;
      err_code <= ERR_NONE;
      mon_succ <= 16'h0000;
      mon_act <= 16'h0000;
      pulse_busy <= 1'b0;
      pulse_done <= 1'b0;
      program_error_flag <= 1'b0;
    end else if (!run_en) begin
      state <= ST_IDLE;
      step_no <= 5'h01;
      from_int <= 1'b0;
      pulse_busy <= 1'b0;
      pulse_done <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          state <= ST_LOAD;
          program_error_flag <= 1'b0;
        end
        ST_LOAD: begin
          err_code <= ld_err;
          from_int <= 1'b0;
          if (ld_err != ERR_NONE) begin
            state <= ST_STOP;
            pulse_busy <= 1'b0;
            program_error_flag <= 1'b1;
          end else begin
            state <= ST_RUN;
            cap <= ld;
            mon_succ <= ld.succ;
            mon_act <= {11'h000, step_no};
            pulse_busy <= 1'b1;
          end
        end
        ST_RUN: begin
          if (int_edge) begin
            step_no <= 5'(int_word);
            from_int <= 1'b1;
            state <= ST_LOAD;
          end else if (step_end && cap.succ == 16'h0000) begin
            state <= ST_STOP;
            pulse_busy <= 1'b0;
            pulse_done <= 1'b1;
          end else if (step_end) begin
            step_no <= 5'(cap.succ);
            state <= ST_LOAD;
          end
        end
        default: begin
          if (int_edge) begin
            step_no <= 5'(int_word);
            from_int <= 1'b1;
            pulse_done <= 1'b0;
            state <= ST_LOAD;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Frequency ramp
  // ----------------------------------------
  // Exact linear ramp without a divider: one unit per clock while the
  // accumulated slope covers a whole 10 ms step of the change time
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_f <= 16'h0000;
      tgt_f <= 16'h0000;
      delta <= 16'h0000;
      rt10 <= 16'h0001;
      hold_left <= 16'h0000;
      racc <= 16'h0000;
      holding <= 1'b0;
    end else if (!run_en || state == ST_IDLE) begin
      cur_f <= 16'h0000;
      racc <= 16'h0000;
      holding <= 1'b0;
    end else if (state == ST_LOAD && ld_err == ERR_NONE) begin
      tgt_f <= ld.freq;
      delta <= (ld.freq > cur_f) ? ld.freq - cur_f : cur_f - ld.freq;
      rt10 <= ld.ramp / RAMP_UNIT;
      hold_left <= ld.ramp / RAMP_UNIT;
      holding <= ld.opts[0];
      racc <= 16'h0000;
    end else if (state == ST_RUN) begin
      if (holding) begin
        if (tick) begin
          hold_left <= hold_left - 16'h0001;
          holding <= hold_left > 16'h0001;
        end
      end else if (cur_f != tgt_f && racc >= rt10) begin
        racc <= racc - rt10;
        cur_f <= (tgt_f > cur_f) ? cur_f + 16'h0001 : cur_f - 16'h0001;
      end else if (cur_f != tgt_f && tick) begin
        racc <= racc + delta;
      end
    end
  end

  // ----------------------------------------
  // Pulse output and count
  // ----------------------------------------
  logic [23:0] inc;
  logic [19:0] inc_units;
  logic toggle;
  assign inc_units = cfg[CFG_MODE] ? 20'(cur_f) * MODE1_SCALE : 20'(cur_f);
  assign inc = {4'h0, inc_units};
  assign toggle = (pacc + inc) >= ACC_HALF;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pacc <= 24'h000000;
      pulse_out <= 1'b0;
      cnt <= 32'h00000000;
    end else if (state != ST_RUN) begin
      pacc <= 24'h000000;
      pulse_out <= 1'b0;
      // A step that ends the sequence keeps its count so the next scan can still report it
      if (state != ST_STOP) begin
        cnt <= 32'h00000000;
      end
    end else if (toggle) begin
      pacc <= pacc + inc - ACC_HALF;
      pulse_out <= ~pulse_out;
      if (!pulse_out && !step_end) begin
        cnt <= cnt + 32'h00000001;
      end
    end else begin
      pacc <= pacc + inc;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mon_cnt <= 32'h00000000;
    end else if (state == ST_LOAD) begin
      mon_cnt <= 32'h00000000;
    end else if (scan_tick && (state == ST_RUN || state == ST_STOP)) begin
      mon_cnt <= cnt;
    end
  end

endmodule // smrp_stepped_ramp_pulser
`default_nettype wire

/* File: tb/smrp_motor_model.sv */
`timescale 1ns/1ns
`default_nettype none
module smrp_motor_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Pulse train and tally
  input wire logic pulse_in,
  output int pulses
);
  logic last;
  // Rising edges only: the driver steps once per pulse
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      last <= 1'b0;
      pulses <= 0;
    end else begin
      last <= pulse_in;
      if (pulse_in && !last) pulses <= pulses + 1;
    end
  end
endmodule // smrp_motor_model
`default_nettype wire

/* File: tb/smrp_props.sv */
`timescale 1ns/1ns
`default_nettype none
module smrp_props (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pulse side
  input wire logic pulse_busy,
  input wire logic pulse_done
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer not held");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer not held");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  aw_taken_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("address not held");
  w_taken_a: assert property (s_axi_wvalid && s_axi_wready |=> !s_axi_wready)
    else $error("data not held");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready && !s_axi_bvalid |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer timing");
  done_idle_a: assert property (pulse_done |-> !pulse_busy)
    else $error("done while busy");
endmodule // smrp_props
bind smrp_stepped_ramp_pulser smrp_props chk_u (.clk(clk), .rst_n(rst_n),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .pulse_busy(pulse_busy), .pulse_done(pulse_done));
`default_nettype wire

/* File: tb/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import smrp_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] awa = 12'h000;
  logic [11:0] ara = 12'h000;
  logic [31:0] wd = 32'h00000000;
  logic awv = 1'b0, wv = 1'b0, brd = 1'b0, arv = 1'b0, rrd = 1'b0;
  // Only this instance listens to irq
  logic rld = 1'b0, irq = 1'b0, fast = 1'b1;
  logic awr, wrdy, bv, arr, rv, pout, busy, done, perr;
  logic [1:0] bresp, rresp;
  logic [31:0] rdat;
  int fails = 0;
  int n_compared = 0;
  int seed = 32'h4df40265;
  int mdl [110];
  int pulses, p0, idx;
  int s12 [12] = '{10000, 10, 0, 5, 0, 2, 5000, 10, 0, 3, 1, 0};
  int mv [9] = '{0, 2, 5000, 10, 0, 3, 0, 3, 0};
  int ci [5] = '{5, 2, 3, 6, 7};
  int cb [5] = '{0, 0, 5, 4, 19};
  int ce [5] = '{3, 4, 5, 7, 8};
  always #25 clk = ~clk;
  smrp_stepped_ramp_pulser #(.SCAN_CYC(20), .TICK_CYC(50)) dut_u (.clk(clk), .rst_n(rst_n),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(brd), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rrd), .defaults_reload_in(rld), .step_interrupt_in(irq),
    .interrupt_fast_sel(fast), .pulse_out(pout), .pulse_busy(busy), .pulse_done(done),
    .program_error_flag(perr));
  smrp_motor_model drv_u (.clk(clk), .rst_n(rst_n), .pulse_in(pout), .pulses(pulses));
  // ----
  // Bus and check tasks
  // ----
  task automatic final_report();
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tmo(input int n, input int lim);
    if (n >= lim) begin
      fails++;
      final_report();
    end
  endtask
  task automatic wr(input int i, input int d, input logic [1:0] er);
    int n;
    awa <= {10'(i), 2'b00};
    wd <= {16'h0000, 16'(d)};
    awv <= 1'b1;
    wv <= 1'b1;
    brd <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
      n++;
    end while (bv !== 1'b1 && n < 400);
    brd <= 1'b0;
    chk("bresp", er, bresp);
    tmo(n, 400);
    @(posedge clk);
  endtask
  task automatic rd(input int i, input logic [31:0] e, input logic [1:0] er);
    int n;
    ara <= {10'(i), 2'b00};
    arv <= 1'b1;
    rrd <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
      n++;
    end while (rv !== 1'b1 && n < 400);
    rrd <= 1'b0;
    chk("rresp", er, rresp);
    chk("rdata", e, rdat);
    tmo(n, 400);
    @(posedge clk);
  endtask
  task automatic setw(input int i, input int d);
    mdl[i] = d;
    wr(i, d, RESP_OKAY);
  endtask
  task automatic run_wait();
    int n;
    n = 0;
    while (done !== 1'b1 && n < 20000) begin
      @(posedge clk);
      n++;
    end
    tmo(n, 20000);
  endtask
  // Model of the control words after reset or reload
  task automatic dflt_all();
    for (int i = 0; i < 110; i++) begin
      mdl[i] = (i == 0) ? 1 : 0;
      if (i >= 2 && (i - 2) % 6 inside {0, 1, 3}) mdl[i] = 100;
    end
  endtask
  task automatic rd_all();
    for (int i = 0; i < 110; i++) rd(i, mdl[i], RESP_OKAY);
  endtask
  // ----
  // Main sequence
  // ----
  initial begin
    dflt_all();
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    rd_all();
    rd(IDX_CFG, 32'h2, RESP_OKAY);
    for (int k = 0; k < 8; k++) begin
      idx = (k == 0) ? 109 : 2 + ($unsigned($random(seed)) % 108);
      setw(idx, $random(seed) & 32'h0000FFFF);
      rd(idx, mdl[idx], RESP_OKAY);
    end
    rd(10'h06E, 32'h0, RESP_DECERR);
    wr(IDX_MON_BASE + 8, 1, RESP_SLVERR);
    $display("test map done");
    for (int i = 0; i < 12; i++) setw(i + 2, s12[i]);
    p0 = pulses;
    wr(IDX_CFG, 7, RESP_OKAY);
    repeat (50) @(posedge clk);
    // Step 1 is running, so its new preset must not apply
    setw(5, 256);
    chk("busy", 1, busy);
    run_wait();
    repeat (60) @(posedge clk);
    chk("pulses", 8, pulses - p0);
    for (int i = 0; i < 9; i++) rd(IDX_MON_BASE + i, mv[i], RESP_OKAY);
    rd(IDX_STAT, 32'h204, RESP_OKAY);
    // Word order flips the monitor halves as well
    wr(IDX_CFG, 0, RESP_OKAY);
    rd(IDX_MON_BASE + 4, 3, RESP_OKAY);
    rd(IDX_MON_BASE + 6, 3, RESP_OKAY);
    setw(5, 5);
    $display("test chain done");
    for (int k = 0; k < 5; k++) begin
      wr(ci[k], cb[k], RESP_OKAY);
      wr(IDX_CFG, 7, RESP_OKAY);
      repeat (5) @(posedge clk);
      chk("error_flag", 1, perr);
      rd(IDX_MON_BASE + 8, ce[k], RESP_OKAY);
      wr(ci[k], mdl[ci[k]], RESP_OKAY);
      wr(IDX_CFG, 2, RESP_OKAY);
    end
    $display("test errors done");
    setw(5, 4096);
    setw(0, 2);
    wr(IDX_CFG, 7, RESP_OKAY);
    repeat (300) @(posedge clk);
    irq <= 1'b1;
    run_wait();
    rd(IDX_MON_BASE + 1, 2, RESP_OKAY);
    wr(IDX_CFG, 2, RESP_OKAY);
    irq <= 1'b0;
    setw(0, 0);
    fast <= 1'b0;
    wr(IDX_CFG, 7, RESP_OKAY);
    repeat (300) @(posedge clk);
    irq <= 1'b1;
    repeat (60) @(posedge clk);
    rd(IDX_MON_BASE + 8, 9, RESP_OKAY);
    irq <= 1'b0;
    wr(IDX_CFG, 2, RESP_OKAY);
    $display("test interrupt done");
    rld <= 1'b1;
    repeat (60) @(posedge clk);
    // A later write is overwritten again by the next scan
    wr(2, 1234, RESP_OKAY);
    repeat (60) @(posedge clk);
    rld <= 1'b0;
    dflt_all();
    rd_all();
    $display("test reload done");
    final_report();
  end
endmodule // tb_top
`default_nettype wire
